// file: rtl/lmir_exec.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lmir_exec
    import lmir_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_we,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             dev_reset_req
);
    function automatic logic [15:0] sext6(input logic [5:0] k);
        sext6 = {{10{k[5]}}, k};
    endfunction

    lmir_state_type state_reg;
    lmir_state_type state_next;
    logic [15:0] instr_reg;
    logic [7:0]  accum_reg;
    logic [4:0]  bank_select_reg;
    logic [6:0]  pc_high_latch_reg;
    logic [15:0] indirect_pointer_reg [2];
    logic [7:0]  option_reg;
    logic [7:0]  power_control_reg;
    logic [7:0]  irq_control_reg;
    logic [14:0] pc_reg;
    logic [7:0]  flags_reg;
    logic [14:0] stack_mem [STACK_DEPTH];
    logic [4:0]  sp_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        mem_we_reg;
    logic [15:0] mem_addr_reg;
    logic [7:0]  mem_wdata_reg;
    logic        dev_reset_req_reg;

    // Bus decode
    wire setup    = psel & ~penable;
    wire busy     = (state_reg != ST_IDLE);
    wire wr_ok    = psel & penable & pwrite & ~busy;
    wire hit_ins  = (paddr == OFF_INSTR);
    wire hit_acc  = (paddr == OFF_ACCUM);
    wire hit_bank = (paddr == OFF_BANK);
    wire hit_page = (paddr == OFF_PAGE);
    wire hit_p0   = (paddr == OFF_PTR0);
    wire hit_p1   = (paddr == OFF_PTR1);
    wire hit_opt  = (paddr == OFF_OPTION);
    wire hit_pwr  = (paddr == OFF_PWRCTL);
    wire hit_irq  = (paddr == OFF_IRQCTL);
    wire hit_pc   = (paddr == OFF_PC);
    wire hit_stk  = (paddr == OFF_STACK);
    wire hit_st   = (paddr == OFF_STATE);
    wire hit_flg  = (paddr == OFF_FLAGS);
    wire mapped   = hit_ins | hit_acc | hit_bank | hit_page | hit_p0
                  | hit_p1 | hit_opt | hit_pwr | hit_irq | hit_pc
                  | hit_stk | hit_st | hit_flg;

    // Instruction decode
    wire [3:0]  op       = instr_reg[15:12];
    wire        exec     = (state_reg == ST_EXEC);
    wire        is_bank  = exec & (op == OP_BANK);
    wire        is_page  = exec & (op == OP_PAGE);
    wire        is_accum = exec & (op == OP_ACCUM);
    wire        is_file  = exec & (op == OP_FILE);
    wire        is_ind   = exec & (op == OP_IND);
    wire        is_rel   = exec & (op == OP_REL);
    wire        is_opt   = exec & (op == OP_OPTION);
    wire        is_soft  = exec & (op == OP_RESET);
    wire        is_ret   = exec & (op == OP_RET_IRQ);
    wire [1:0]  upd_code = instr_reg[1:0];
    wire        ind_sel  = (op == OP_REL) ? instr_reg[REL_N_BIT]
                                          : instr_reg[IND_N_BIT];
    wire [15:0] ptr_cur  = indirect_pointer_reg[ind_sel];
    wire [15:0] step     = upd_code[0] ? 16'hFFFF : 16'h0001;
    wire [15:0] ptr_step = ptr_cur + step;
    wire [15:0] rel_addr = ptr_cur + sext6(instr_reg[5:0]);
    wire [15:0] ind_addr = (op == OP_REL) ? rel_addr
                         : (upd_code[1] ? ptr_cur : ptr_step);
    wire        ptr_we   = is_ind;
    wire [6:0]  file_f   = instr_reg[6:0];
    wire        win_hit  = (file_f == WIN0_ADDR) | (file_f == WIN1_ADDR);
    wire        win_n    = (file_f == WIN1_ADDR);
    wire [15:0] file_adr = win_hit ? indirect_pointer_reg[win_n]
                         : {4'h0, bank_select_reg, file_f};
    wire [14:0] stack_top = (sp_reg == 5'h00) ? PC_RST
                          : stack_mem[4'(sp_reg - 5'h01)];
    wire        push     = wr_ok & hit_stk & (sp_reg != SP_FULL);

    // Read data
    wire [31:0] rd_word =
          ({32{hit_ins}}  & {16'h0000, instr_reg})
        | ({32{hit_acc}}  & {24'h00_0000, accum_reg})
        | ({32{hit_bank}} & {27'h000_0000, bank_select_reg})
        | ({32{hit_page}} & {25'h000_0000, pc_high_latch_reg})
        | ({32{hit_p0}}   & {16'h0000, indirect_pointer_reg[0]})
        | ({32{hit_p1}}   & {16'h0000, indirect_pointer_reg[1]})
        | ({32{hit_opt}}  & {24'h00_0000, option_reg})
        | ({32{hit_pwr}}  & {24'h00_0000, power_control_reg})
        | ({32{hit_irq}}  & {24'h00_0000, irq_control_reg})
        | ({32{hit_pc}}   & {17'h0_0000, pc_reg})
        | ({32{hit_stk}}  & {17'h0_0000, stack_top})
        | ({32{hit_st}}   & {19'h0_0000, sp_reg, 7'h00, busy})
        | ({32{hit_flg}}  & {24'h00_0000, flags_reg});

    always_comb begin
        case (state_reg)
            ST_IDLE:   state_next = (wr_ok & hit_ins) ? ST_EXEC : ST_IDLE;
            ST_EXEC:   state_next = is_ret ? ST_SECOND : ST_IDLE;
            ST_SECOND: state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= 1'b1;
            if (setup) begin
                pslverr_reg <= ~mapped;
                prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= INSTR_RST;
        end else if (wr_ok & hit_ins) begin
            instr_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_reg <= ACCUM_RST;
        end else if (is_soft) begin
            accum_reg <= ACCUM_RST;
        end else if (is_accum) begin
            accum_reg <= instr_reg[7:0];
        end else if (wr_ok & hit_acc) begin
            accum_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_reg <= BANK_RST;
        end else if (is_soft) begin
            bank_select_reg <= BANK_RST;
        end else if (is_bank) begin
            bank_select_reg <= {1'b0, instr_reg[3:0]};
        end else if (wr_ok & hit_bank) begin
            bank_select_reg <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_high_latch_reg <= PAGE_RST;
        end else if (is_soft) begin
            pc_high_latch_reg <= PAGE_RST;
        end else if (is_page) begin
            pc_high_latch_reg <= instr_reg[6:0];
        end else if (wr_ok & hit_page) begin
            pc_high_latch_reg <= pwdata[6:0];
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                indirect_pointer_reg[i] <= PTR_RST;
            end else if (is_soft) begin
                indirect_pointer_reg[i] <= PTR_RST;
            end else if (ptr_we & (ind_sel == 1'(i))) begin
                indirect_pointer_reg[i] <= ptr_step;
            end else if (wr_ok & (i == 0 ? hit_p0 : hit_p1)) begin
                indirect_pointer_reg[i] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg <= OPTION_RST;
        end else if (is_soft) begin
            option_reg <= OPTION_RST;
        end else if (is_opt) begin
            option_reg <= accum_reg;
        end else if (wr_ok & hit_opt) begin
            option_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_reg <= PWRCTL_RST;
        end else if (is_soft) begin
            power_control_reg <= PWRCTL_RST & ~(8'h01 << SRF_N_BIT);
        end else if (wr_ok & hit_pwr) begin
            power_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_control_reg <= IRQCTL_RST;
        end else if (is_soft) begin
            irq_control_reg <= IRQCTL_RST;
        end else if (is_ret) begin
            irq_control_reg[IRQ_EN_BIT] <= 1'b1;
        end else if (wr_ok & hit_irq) begin
            irq_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= PC_RST;
            sp_reg <= 5'h00;
        end else if (is_soft) begin
            pc_reg <= PC_RST;
            sp_reg <= 5'h00;
        end else if (is_ret) begin
            pc_reg <= stack_top;
            sp_reg <= (sp_reg == 5'h00) ? 5'h00 : sp_reg - 5'h01;
        end else begin
            if (wr_ok & hit_pc) begin
                pc_reg <= pwdata[14:0];
            end
            if (push) begin
                sp_reg <= sp_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            stack_mem[sp_reg[3:0]] <= pwdata[14:0];
        end
    end

    // Flags change only by an APB write or the soft reset instruction, which clears them; no other operation touches them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RST;
        end else if (is_soft) begin
            flags_reg <= FLAGS_RST;
        end else if (wr_ok & hit_flg) begin
            flags_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we_reg        <= 1'b0;
            mem_addr_reg      <= 16'h0000;
            mem_wdata_reg     <= 8'h00;
            dev_reset_req_reg <= 1'b0;
        end else begin
            mem_we_reg        <= is_file | is_ind | is_rel;
            mem_addr_reg      <= is_file ? file_adr : ind_addr;
            mem_wdata_reg     <= accum_reg;
            dev_reset_req_reg <= is_soft;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign mem_we        = mem_we_reg;
    assign mem_addr      = mem_addr_reg;
    assign mem_wdata     = mem_wdata_reg;
    assign dev_reset_req = dev_reset_req_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start(logic [3:0] code);
        wr_ok && hit_ins && pwdata[15:12] == code;
    endsequence

    sequence s_two_cycles;
        state_reg == ST_EXEC ##1 state_reg == ST_SECOND
        ##1 state_reg == ST_IDLE;
    endsequence

    a_bank_zero_ext: assert property (
        s_start(OP_BANK) |=> ##1
            bank_select_reg == {1'b0, $past(pwdata[3:0], 2)})
        else $error("bank select not loaded");
    a_page_load: assert property (
        is_page |=> pc_high_latch_reg == $past(instr_reg[6:0]))
        else $error("pc high latch not loaded");
    a_accum_one_cycle: assert property (
        s_start(OP_ACCUM) |=> ##1
            (accum_reg == $past(pwdata[7:0], 2) && !busy))
        else $error("accumulator literal late or wrong");
    a_file_store: assert property (
        is_file |=> mem_we && mem_wdata == $past(accum_reg))
        else $error("file store missing");
    a_rel_address: assert property (
        is_rel |=> mem_addr == $past(rel_addr)
            && $stable(indirect_pointer_reg[0])
            && $stable(indirect_pointer_reg[1]))
        else $error("relative store wrong");
    a_pre_update: assert property (
        is_ind && !upd_code[1] |=>
            indirect_pointer_reg[$past(ind_sel)] == mem_addr)
        else $error("pre update wrong");
    a_post_update: assert property (
        is_ind && upd_code[1] |=> mem_addr == $past(ptr_cur)
            && indirect_pointer_reg[$past(ind_sel)] == $past(ptr_step))
        else $error("post update wrong");
    a_window_route: assert property (
        is_file && win_hit |=> mem_addr == $past(file_adr)
            && mem_addr == $past(indirect_pointer_reg[win_n]))
        else $error("window not routed to pointer");
    a_pointer_wrap: assert property (
        is_ind && upd_code == 2'b00 && ptr_cur == 16'hFFFF
            |=> mem_addr == 16'h0000)
        else $error("pointer did not wrap");
    a_flags_kept: assert property (
        exec && !is_soft |=> $stable(flags_reg))
        else $error("flags changed");
    a_option_load: assert property (
        is_opt |=> option_reg == $past(accum_reg))
        else $error("option not loaded");
    a_soft_reset: assert property (
        is_soft |=> dev_reset_req && !power_control_reg[SRF_N_BIT]
            ##1 !dev_reset_req)
        else $error("software reset wrong");
    a_return_pop: assert property (
        is_ret && sp_reg != 5'h00 |=> pc_reg == $past(stack_top)
            && irq_control_reg[IRQ_EN_BIT] && sp_reg == $past(sp_reg) - 5'h01)
        else $error("return pop wrong");
    a_return_cycles: assert property (
        is_ret |-> s_two_cycles)
        else $error("return not two cycles");
endmodule
`default_nettype wire

// file: rtl/lmir_pkg.sv
package lmir_pkg;
    localparam logic [7:0]  OFF_INSTR   = 8'h00;
    localparam logic [7:0]  OFF_ACCUM   = 8'h04;
    localparam logic [7:0]  OFF_BANK    = 8'h08;
    localparam logic [7:0]  OFF_PAGE    = 8'h0C;
    localparam logic [7:0]  OFF_PTR0    = 8'h10;
    localparam logic [7:0]  OFF_PTR1    = 8'h14;
    localparam logic [7:0]  OFF_OPTION  = 8'h18;
    localparam logic [7:0]  OFF_PWRCTL  = 8'h1C;
    localparam logic [7:0]  OFF_IRQCTL  = 8'h20;
    localparam logic [7:0]  OFF_PC      = 8'h24;
    localparam logic [7:0]  OFF_STACK   = 8'h28;
    localparam logic [7:0]  OFF_STATE   = 8'h2C;
    localparam logic [7:0]  OFF_FLAGS   = 8'h30;
    localparam logic [3:0]  OP_BANK     = 4'h1;
    localparam logic [3:0]  OP_PAGE     = 4'h2;
    localparam logic [3:0]  OP_ACCUM    = 4'h3;
    localparam logic [3:0]  OP_FILE     = 4'h4;
    localparam logic [3:0]  OP_IND      = 4'h5;
    localparam logic [3:0]  OP_REL      = 4'h6;
    localparam logic [3:0]  OP_OPTION   = 4'h7;
    localparam logic [3:0]  OP_RESET    = 4'h8;
    localparam logic [3:0]  OP_RET_IRQ  = 4'h9;
    localparam int          IND_N_BIT   = 2;
    localparam int          REL_N_BIT   = 6;
    localparam int          IRQ_EN_BIT  = 7;
    localparam int          SRF_N_BIT   = 2;
    localparam int          STATE_SP_LSB = 8;
    localparam logic [6:0]  WIN0_ADDR   = 7'h00;
    localparam logic [6:0]  WIN1_ADDR   = 7'h01;
    localparam int          STACK_DEPTH = 16;
    localparam logic [4:0]  SP_FULL     = 5'h10;
    localparam logic [7:0]  ACCUM_RST   = 8'h00;
    localparam logic [4:0]  BANK_RST    = 5'h00;
    localparam logic [6:0]  PAGE_RST    = 7'h00;
    localparam logic [15:0] PTR_RST     = 16'h0000;
    localparam logic [7:0]  OPTION_RST  = 8'hFF;
    localparam logic [7:0]  PWRCTL_RST  = 8'h04;
    localparam logic [7:0]  IRQCTL_RST  = 8'h00;
    localparam logic [14:0] PC_RST      = 15'h0000;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic [15:0] INSTR_RST   = 16'h0000;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_SECOND = 2'b11
    } lmir_state_type;
endpackage

// file: sim/tb_literal_move_indirect_return_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_literal_move_indirect_return_exec;
    import lmir_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        dev_reset_req;
    int          fail_count = 0;
    int          checked = 0;
    int          we_cnt = 0;
    int          rst_cnt = 0;
    logic [15:0] we_addr;
    logic [7:0]  we_data;

    lmir_exec u_lmir_exec (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .mem_we        (mem_we),
        .mem_addr      (mem_addr),
        .mem_wdata     (mem_wdata),
        .dev_reset_req (dev_reset_req)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // Write strobe and soft reset pulses are one cycle wide
    always @(posedge pclk) begin
        if (mem_we === 1'b1) begin
            we_cnt  = we_cnt + 1;
            we_addr = mem_addr;
            we_data = mem_wdata;
        end
        if (dev_reset_req === 1'b1) rst_cnt = rst_cnt + 1;
    end

    task automatic tally_and_finish();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("[ERR] %0t no pready", $time);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        check(r, exp);
    endtask

    task automatic exec(input logic [15:0] ins);
        logic [31:0] r;
        logic        e;
        int          n;
        wr(OFF_INSTR, {16'h0000, ins});
        n = 0;
        do begin
            apb(OFF_STATE, 1'b0, 32'h0000_0000, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("[ERR] %0t instruction hangs", $time);
        end
    endtask

    logic [15:0] p;
    logic [15:0] np;
    logic [15:0] ea;
    logic [7:0]  pa;
    logic [7:0]  oa;
    logic [5:0]  rk [2];
    logic [15:0] rp [2];
    logic [15:0] re [2];
    logic [31:0] e_r;
    logic        e_e;
    int          w0;

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_ACCUM, 32'h0000_0000);
        rd(OFF_OPTION, 32'h0000_00FF);
        rd(OFF_PWRCTL, 32'h0000_0004);
        rd(OFF_PTR1, 32'h0000_0000);
        apb(8'h3C, 1'b0, 32'h0000_0000, e_r, e_e);
        check({31'h0, e_e}, 32'h0000_0001);
        $display("test reset_and_map done");
        wr(OFF_FLAGS, 32'h0000_00A5);
        exec(16'h30FF);
        rd(OFF_ACCUM, 32'h0000_00FF);
        exec(16'h305A);
        rd(OFF_ACCUM, 32'h0000_005A);
        wr(OFF_BANK, 32'h0000_001F);
        exec(16'h100F);
        rd(OFF_BANK, 32'h0000_000F);
        exec(16'h207F);
        rd(OFF_PAGE, 32'h0000_007F);
        rd(OFF_FLAGS, 32'h0000_00A5);
        $display("test literal_loads done");
        exec(16'h1003);
        w0 = we_cnt;
        exec(16'h4045);
        check(we_cnt, w0 + 1);
        check({16'h0, we_addr}, 32'h0000_01C5);
        check({24'h0, we_data}, 32'h0000_005A);
        wr(OFF_PTR0, 32'h0000_1234);
        wr(OFF_PTR1, 32'h0000_BEEF);
        exec(16'h4000);
        check({16'h0, we_addr}, 32'h0000_1234);
        exec(16'h4001);
        check({16'h0, we_addr}, 32'h0000_BEEF);
        check(we_cnt, w0 + 3);
        $display("test file_store done");
        for (int n = 0; n < 2; n++) begin
            for (int c = 0; c < 4; c++) begin
                p  = (c == 0 || c == 2) ? 16'hFFFF : 16'h0000;
                np = (c == 0 || c == 2) ? p + 16'h0001 : p - 16'h0001;
                ea = (c < 2) ? np : p;
                pa = (n == 1) ? OFF_PTR1 : OFF_PTR0;
                oa = (n == 1) ? OFF_PTR0 : OFF_PTR1;
                wr(oa, 32'h0000_1234);
                wr(pa, {16'h0, p});
                w0 = we_cnt;
                exec(16'h5000 | 16'(n << IND_N_BIT) | 16'(c));
                check(we_cnt, w0 + 1);
                check({16'h0, we_addr}, {16'h0, ea});
                check({24'h0, we_data}, 32'h0000_005A);
                rd(pa, {16'h0, np});
                rd(oa, 32'h0000_1234);
            end
        end
        rd(OFF_FLAGS, 32'h0000_00A5);
        $display("test indirect_modes done");
        rk[0] = 6'h20;
        rp[0] = 16'h0010;
        re[0] = 16'hFFF0;
        rk[1] = 6'h1F;
        rp[1] = 16'hFFF0;
        re[1] = 16'h000F;
        for (int n = 0; n < 2; n++) begin
            pa = (n == 1) ? OFF_PTR1 : OFF_PTR0;
            wr(pa, {16'h0, rp[n]});
            exec(16'h6000 | 16'(n << REL_N_BIT) | {10'h0, rk[n]});
            check({16'h0, we_addr}, {16'h0, re[n]});
            rd(pa, {16'h0, rp[n]});
        end
        rd(OFF_FLAGS, 32'h0000_00A5);
        $display("test relative_store done");
        exec(16'h304F);
        exec(16'h7000);
        rd(OFF_OPTION, 32'h0000_004F);
        $display("test option_load done");
        wr(OFF_IRQCTL, 32'h0000_0000);
        wr(OFF_STACK, 32'h0000_0123);
        wr(OFF_STACK, 32'h0000_0456);
        exec(16'h9000);
        rd(OFF_PC, 32'h0000_0456);
        rd(OFF_STACK, 32'h0000_0123);
        rd(OFF_IRQCTL, 32'h0000_0080);
        rd(OFF_STATE, 32'h0000_0100);
        rd(OFF_FLAGS, 32'h0000_00A5);
        $display("test return_from_interrupt done");
        w0 = rst_cnt;
        exec(16'h8000);
        check(rst_cnt, w0 + 1);
        rd(OFF_PWRCTL, 32'h0000_0000);
        rd(OFF_ACCUM, 32'h0000_0000);
        rd(OFF_OPTION, 32'h0000_00FF);
        rd(OFF_PTR0, 32'h0000_0000);
        $display("test soft_reset done");
        tally_and_finish();
    end

    initial begin
        #200_000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
